/* rtl/ds0_timeslot_port_mapper.sv */
// Time-slot port mapper for a single V.35 super-rate port, with its data FIFO
//
// Overview of operation
// - A standby port claims no time slots; only an active port drives its slot claims.
// - Standby is the reset state for an unconfigured port, active marks a port ready for traffic.
// - Selectable slots are 1 to 24 on a T1 link and 1 to 31 on an E1 link.
// - On an E1 link with CAS or CCS signaling, slot 16 can never be assigned.
// - A port may bundle one up to all slots, all taken from one WAN port.
// - The slot set may be any non-contiguous combination of positions.
// - Port speed is the 56k or 64k per-slot rate times the number of assigned slots.
// - With a WAN destination, data goes to one WAN port from w1-1 to w4-2.
// - With a user destination, data goes to a port of a card in user slot U1 to U8.
// - A requested user port beyond the ports present on that card becomes port 1.
// - The server destination type is refused; only WAN and user are accepted.
// - The port always presents itself as DCE and this cannot be changed.
// - Transmit clock is internal, clock and data polarity are normal, all fixed.
// - DDS loop code allows off, OCU, CSU, DSU or DS0 commands; V.54 and FT1 allow off and on.
// - CTS is permanently on with zero delay; local loopback resets to off and takes off, DTE or net.
`timescale 1ns/1ps
`default_nettype none

module ds0_data_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             mclk_i,   // Clock
	input  wire logic             rst_i,    // Sync reset
	input  wire logic [WIDTH-1:0] wdata_i,  // Write data
	input  wire logic             wvalid_i, // Write valid
	output logic                  wready_o, // Not full
	output logic      [WIDTH-1:0] rdata_o,  // Head word
	output logic                  rvalid_o, // Not empty
	input  wire logic             rready_i  // Drain
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wptr_q;
	logic [AW-1:0]    rptr_q;
	logic [AW:0]      cnt_q;
	logic [AW:0]      cnt_d;
	logic             wready_q;
	logic             push;
	logic             pop;

	assign push     = wvalid_i && wready_o;
	assign pop      = rvalid_o && rready_i;
	// Room flag kept in a flop so the ready leaves a register
	assign wready_o = wready_q;
	assign cnt_d    = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	assign rvalid_o = (cnt_q != '0);
	assign rdata_o  = mem_q[rptr_q];

	always_ff @(posedge mclk_i) begin
		if (push) begin
			mem_q[wptr_q] <= wdata_i;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			wptr_q <= '0;
			rptr_q <= '0;
			cnt_q    <= '0;
			wready_q <= 1'b1;
		end else begin
			if (push) begin
				wptr_q <= (wptr_q == AW'(DEPTH-1)) ? '0 : wptr_q + 1'b1;
			end
			if (pop) begin
				rptr_q <= (rptr_q == AW'(DEPTH-1)) ? '0 : rptr_q + 1'b1;
			end
			cnt_q    <= cnt_d;
			wready_q <= (cnt_d != (AW+1)'(DEPTH));
		end
	end
endmodule

module ds0_timeslot_port_mapper #(
	parameter int FIFO_W = ds0_map_pkg::FIFO_WIDTH,
	parameter int FIFO_D = ds0_map_pkg::FIFO_DEPTH
) (
	input  wire logic                            mclk_i,       // 100 MHz clock
	input  wire logic                            rst_i,        // Sync reset, high
	input  wire logic [ds0_map_pkg::ADDR_W-1:0]  addr_i,       // Register address
	input  wire logic [ds0_map_pkg::DATA_W-1:0]  wdata_i,      // Write data
	input  wire logic                            wr_i,         // Write strobe
	input  wire logic                            rd_i,         // Read strobe
	output logic      [ds0_map_pkg::DATA_W-1:0]  rdata_o,      // Read data, next cycle
	output logic      [ds0_map_pkg::NUM_SLOTS-1:0] slot_claim_o, // Slots claimed on link
	output logic                                 dest_user_o,  // 1 user card, 0 WAN
	output logic      [2:0]                      wan_port_o,   // 0 = w1-1 .. 7 = w4-2
	output logic      [2:0]                      user_slot_o,  // 0 = U1 .. 7 = U8
	output logic      [2:0]                      user_port_o,  // Resolved user port
	output logic      [ds0_map_pkg::KBPS_W-1:0]  speed_kbps_o, // Port throughput
	output logic                                 cts_o,        // Clear to send
	output logic                                 dce_o,        // DCE role
	output logic      [1:0]                      local_loopback_select_o,   // Local loopback select
	output logic      [1:0]                      loop_type_o,  // Loop code type
	output logic      [2:0]                      loop_cmd_o,   // Loop command
	input  wire logic [FIFO_W-1:0]               din_i,        // Port data in
	input  wire logic                            din_valid_i,  // Data in valid
	output logic                                 din_ready_o,  // FIFO has room
	output logic      [FIFO_W-1:0]               dout_o,       // Data toward link
	output logic                                 dout_valid_o, // Data out valid
	input  wire logic                            dout_ready_i  // Link takes data
);
	import ds0_map_pkg::*;

	localparam int UPORTS_W = USER_SLOTS * UPORT_W;

	// Slots that the link type allows; bit 0 is slot 1
	function automatic logic [NUM_SLOTS-1:0] allowed_slots(input logic e1, input logic sig);
		logic [NUM_SLOTS-1:0] m;
		m = '0;
		for (int i = 0; i < NUM_SLOTS; i++) begin
			m[i] = e1 ? !(sig && (i == E1_SIG_SLOT-1)) : (i < T1_SLOTS);
		end
		return m;
	endfunction

	function automatic logic [SLOT_CNT_W-1:0] count_slots(input logic [NUM_SLOTS-1:0] m);
		logic [SLOT_CNT_W-1:0] c;
		c = '0;
		for (int i = 0; i < NUM_SLOTS; i++) begin
			c = c + SLOT_CNT_W'(m[i]);
		end
		return c;
	endfunction

	logic                   active_q;
	logic                   active_d;
	destination_type_e      dest_q;
	destination_type_e      dest_d;
	logic [2:0]             wan_q;
	logic [2:0]             uslot_q;
	logic [2:0]             uport_q;
	logic                   rate64_q;
	local_loopback_select_e llb_q;
	local_loopback_select_e llb_d;
	loop_code_type_e        lct_q;
	loop_code_type_e        lct_d;
	logic [2:0]             lcmd_q;
	logic [2:0]             lcmd_d;
	logic                   e1_q;
	logic                   sig_q;
	logic [UPORTS_W-1:0]    uports_q;
	logic [NUM_SLOTS-1:0]   mask_q;
	logic [NUM_SLOTS-1:0]   mask_d;
	logic [DATA_W-1:0]      rdata_q;
	logic [NUM_SLOTS-1:0]   claim_q;
	logic [KBPS_W-1:0]      speed_q;
	logic                   dout_valid_q;
	logic [FIFO_W-1:0]      dout_q;
	logic                   dest_user_q;
	logic                   cts_q;
	logic                   dce_q;

	// Register strobes and write fields
	wire logic                   wr_ctrl  = wr_i && (addr_i == REG_CTRL);
	wire logic                   wr_link  = wr_i && (addr_i == REG_LINK);
	wire logic                   wr_upts  = wr_i && (addr_i == REG_UPORTS);
	wire logic                   wr_slots = wr_i && (addr_i == REG_SLOTS);
	wire logic                   new_e1   = wr_link ? wdata_i[LINK_E1] : e1_q;
	wire logic                   new_sig  = wr_link ? wdata_i[LINK_SIG] : sig_q;
	wire logic [NUM_SLOTS-1:0]   allow    = allowed_slots(new_e1, new_sig);
	wire logic [1:0]             w_dest   = wdata_i[CTRL_DEST_LO +: 2];
	wire logic [1:0]             w_llb    = wdata_i[CTRL_LLB_LO +: 2];
	wire logic [1:0]             w_lct    = wdata_i[CTRL_LCT_LO +: 2];
	wire logic [2:0]             w_lcmd   = wdata_i[CTRL_LCMD_LO +: 3];
	wire logic [2:0]             w_uslot  = wdata_i[CTRL_USLOT_LO +: 3];
	wire logic [2:0]             w_uport  = wdata_i[CTRL_UPORT_LO +: 3];
	wire logic [2:0]             u_avail  = uports_q[w_uslot*UPORT_W +: UPORT_W];
	// Port zero or one beyond the card's ports falls back to port 1
	wire logic [2:0]             uport_d  = (w_uport == 3'h0 || w_uport > u_avail) ?
		UPORT_FIRST : w_uport;
	// Speed follows the stored mask one cycle later
	wire logic [SLOT_CNT_W-1:0]  n_slots  = count_slots(mask_q);
	wire logic [KBPS_W-1:0]      per_slot = rate64_q ? KBPS_64 : KBPS_56;
	wire logic [KBPS_W-1:0]      speed    = KBPS_W'(per_slot * n_slots);

	// Server destination and reserved codes leave the old choice in place
	assign dest_d = (wr_ctrl && (w_dest == DEST_WAN || w_dest == DEST_USER)) ?
		destination_type_e'(w_dest) : dest_q;
	assign llb_d  = (wr_ctrl && w_llb != LLB_RSVD) ? local_loopback_select_e'(w_llb) : llb_q;
	assign lct_d  = (wr_ctrl && w_lct != LCT_RSVD) ? loop_code_type_e'(w_lct) : lct_q;
	// Loop command must be legal for the code type in force after the write
	assign lcmd_d = !wr_ctrl ? lcmd_q :
		(lct_d == LCT_DDS) ? ((w_lcmd <= LCMD_DS0) ? w_lcmd : lcmd_q) :
		((w_lcmd <= LCMD_ON) ? w_lcmd : LCMD_OFF);
	assign active_d = wr_ctrl ? wdata_i[CTRL_ACTIVE] : active_q;
	// Mask always re-trimmed to what the link allows
	assign mask_d = (wr_slots ? wdata_i[NUM_SLOTS-1:0] : mask_q) & allow;

	// Port state and destination
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			active_q    <= 1'b0;
			dest_q      <= DEST_WAN;
			dest_user_q <= 1'b0;
		end else begin
			active_q    <= active_d;
			dest_q      <= dest_d;
			dest_user_q <= (dest_d == DEST_USER);
		end
	end

	// Routing target and per-slot rate, taken on a control write
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			wan_q    <= WAN_DEFAULT;
			uslot_q  <= '0;
			uport_q  <= UPORT_FIRST;
			rate64_q <= 1'b0;
		end else if (wr_ctrl) begin
			wan_q    <= wdata_i[CTRL_WAN_LO +: 3];
			uslot_q  <= w_uslot;
			uport_q  <= uport_d;
			rate64_q <= wdata_i[CTRL_RATE64];
		end
	end

	// Loopback selections
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			llb_q  <= LLB_OFF;
			lct_q  <= LCT_DDS;
			lcmd_q <= LCMD_OFF;
		end else begin
			llb_q  <= llb_d;
			lct_q  <= lct_d;
			lcmd_q <= lcmd_d;
		end
	end

	// Link type, user card port counts and the slot mask
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			e1_q     <= 1'b0;
			sig_q    <= 1'b0;
			uports_q <= UPORTS_RESET;
			mask_q   <= '0;
		end else begin
			e1_q     <= new_e1;
			sig_q    <= new_sig;
			mask_q   <= mask_d;
			if (wr_upts) begin
				uports_q <= wdata_i[UPORTS_W-1:0];
			end
		end
	end

	// Fixed role and clear to send
	always_ff @(posedge mclk_i) begin
		cts_q <= 1'b1;
		dce_q <= 1'b1;
	end

	// Read mux
	wire logic [DATA_W-1:0] ctrl_rd = DATA_W'({lcmd_q, lct_q, llb_q, rate64_q, uport_q,
		uslot_q, wan_q, dest_q, active_q});
	// Fixed port identity and the stored slot count
	logic [DATA_W-1:0] status_rd;
	always_comb begin
		status_rd                                    = '0;
		status_rd[ST_DCE]                            = 1'b1;
		status_rd[ST_INT_CLK]                        = 1'b1;
		status_rd[ST_CLK_INV]                        = 1'b0;
		status_rd[ST_DATA_INV]                       = 1'b0;
		status_rd[ST_CTS_PERM]                       = 1'b1;
		status_rd[ST_CTS_DLY_LO +: $bits(CTS_DELAY)] = CTS_DELAY;
		status_rd[ST_COUNT_LO +: SLOT_CNT_W]         = n_slots;
	end
	wire logic [DATA_W-1:0] rd_mux =
		(addr_i == REG_CTRL)   ? ctrl_rd :
		(addr_i == REG_LINK)   ? DATA_W'({sig_q, e1_q}) :
		(addr_i == REG_UPORTS) ? DATA_W'(uports_q) :
		(addr_i == REG_SLOTS)  ? DATA_W'(mask_q) :
		(addr_i == REG_STATUS) ? status_rd :
		(addr_i == REG_SPEED)  ? DATA_W'(speed_q) : '0;

	// Read data, slot claims and speed
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			rdata_q <= '0;
			claim_q <= '0;
			speed_q <= '0;
		end else begin
			rdata_q <= rd_i ? rd_mux : '0;
			claim_q <= active_d ? mask_d : '0;
			speed_q <= speed;
		end
	end

	// Data path: FIFO then an output register; standby holds data back
	logic [FIFO_W-1:0] f_data;
	logic              f_valid;
	wire logic         out_free = !dout_valid_q || dout_ready_i;
	wire logic         f_take   = f_valid && out_free && active_q;

	ds0_data_fifo #(
		.WIDTH (FIFO_W),
		.DEPTH (FIFO_D)
	) u_fifo (
		.mclk_i   (mclk_i),
		.rst_i    (rst_i),
		.wdata_i  (din_i),
		.wvalid_i (din_valid_i),
		.wready_o (din_ready_o),
		.rdata_o  (f_data),
		.rvalid_o (f_valid),
		.rready_i (f_take)
	);

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			dout_valid_q <= 1'b0;
			dout_q       <= '0;
		end else if (out_free) begin
			dout_valid_q <= f_take;
			if (f_take) begin
				dout_q <= f_data;
			end
		end
	end

	assign rdata_o      = rdata_q;
	assign slot_claim_o = claim_q;
	assign dest_user_o  = dest_user_q;
	assign wan_port_o   = wan_q;
	assign user_slot_o  = uslot_q;
	assign user_port_o  = uport_q;
	assign speed_kbps_o = speed_q;
	assign cts_o        = cts_q;
	assign dce_o        = dce_q;
	assign local_loopback_select_o   = llb_q;
	assign loop_type_o  = lct_q;
	assign loop_cmd_o   = lcmd_q;
	assign dout_o       = dout_q;
	assign dout_valid_o = dout_valid_q;
endmodule

`default_nettype wire

/* rtl/ds0_map_pkg.sv */
// Constants shared by the time-slot port mapper and its data FIFO
package ds0_map_pkg;
	localparam int          ADDR_W        = 8;
	localparam int          DATA_W        = 32;
	localparam int          NUM_SLOTS     = 31;
	localparam int          T1_SLOTS      = 24;
	localparam int          E1_SIG_SLOT   = 16;
	localparam int          SLOT_CNT_W    = 5;
	localparam int          KBPS_W        = 11;
	localparam int          FIFO_DEPTH    = 16;
	localparam int          FIFO_WIDTH    = 8;
	localparam int          USER_SLOTS    = 8;
	localparam int          UPORT_W       = 3;

	// Register offsets
	localparam logic [7:0]  REG_CTRL      = 8'h00;
	localparam logic [7:0]  REG_LINK      = 8'h04;
	localparam logic [7:0]  REG_UPORTS    = 8'h08;
	localparam logic [7:0]  REG_SLOTS     = 8'h0c;
	localparam logic [7:0]  REG_STATUS    = 8'h10;
	localparam logic [7:0]  REG_SPEED     = 8'h14;

	// CTRL field positions
	localparam int          CTRL_ACTIVE   = 0;
	localparam int          CTRL_DEST_LO  = 1;
	localparam int          CTRL_WAN_LO   = 3;
	localparam int          CTRL_USLOT_LO = 6;
	localparam int          CTRL_UPORT_LO = 9;
	localparam int          CTRL_RATE64   = 12;
	localparam int          CTRL_LLB_LO   = 13;
	localparam int          CTRL_LCT_LO   = 15;
	localparam int          CTRL_LCMD_LO  = 17;
	// LINK field positions
	localparam int          LINK_E1       = 0;
	localparam int          LINK_SIG      = 1;
	// STATUS field positions
	localparam int          ST_DCE        = 0;
	localparam int          ST_INT_CLK    = 1;
	localparam int          ST_CLK_INV    = 2;
	localparam int          ST_DATA_INV   = 3;
	localparam int          ST_CTS_PERM   = 4;
	localparam int          ST_CTS_DLY_LO = 8;
	localparam int          ST_COUNT_LO   = 16;

	localparam logic [7:0]  CTS_DELAY     = 8'h00;
	localparam logic [10:0] KBPS_56       = 11'h038;
	localparam logic [10:0] KBPS_64       = 11'h040;
	localparam logic [2:0]  UPORT_FIRST   = 3'h1;
	localparam logic [2:0]  WAN_DEFAULT   = 3'h0;
	localparam logic [23:0] UPORTS_RESET  = 24'h000000;

	typedef enum logic [1:0] {DEST_WAN, DEST_SERV, DEST_USER, DEST_RSVD} destination_type_e;
	typedef enum logic [1:0] {LLB_OFF, LLB_DTE, LLB_NET, LLB_RSVD} local_loopback_select_e;
	typedef enum logic [1:0] {LCT_DDS, LCT_V54, LCT_FT1, LCT_RSVD} loop_code_type_e;
	typedef enum logic [2:0] {LCMD_OFF, LCMD_OCU, LCMD_CSU, LCMD_DSU, LCMD_DS0} loop_command_e;
	localparam logic [2:0]  LCMD_ON       = 3'h1;
endpackage

/* sim/ds0_map_props.sv */
// Checker for the time-slot port mapper ports
`timescale 1ns/1ps
`default_nettype none
module ds0_map_props
	import ds0_map_pkg::*;
#(
	parameter int FIFO_W = 8
) (
	input wire logic                 mclk_i,       // Clock
	input wire logic                 rst_i,        // Sync reset
	input wire logic [NUM_SLOTS-1:0] slot_claim_o, // Claimed slots
	input wire logic [KBPS_W-1:0]    speed_kbps_o, // Throughput
	input wire logic [2:0]           user_port_o,  // Resolved port
	input wire logic                 cts_o,        // Clear to send
	input wire logic                 dce_o,        // DCE role
	input wire logic                 dest_user_o,  // User destination
	input wire logic [1:0]           local_loopback_select_o,   // Local loopback
	input wire logic [1:0]           loop_type_o,  // Loop code type
	input wire logic [2:0]           loop_cmd_o,   // Loop command
	input wire logic [FIFO_W-1:0]    dout_o,       // Link data
	input wire logic                 dout_valid_o, // Link valid
	input wire logic                 dout_ready_i  // Link ready
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	cts_perm_a: assert property (cts_o)
		else $error("clear to send dropped");
	dce_role_a: assert property (dce_o)
		else $error("role is not dce");
	speed_rate_a: assert property ($stable(slot_claim_o) && slot_claim_o != '0 |->
		speed_kbps_o == KBPS_W'(56 * $countones(slot_claim_o)) ||
		speed_kbps_o == KBPS_W'(64 * $countones(slot_claim_o)))
		else $error("speed not rate times slots");
	user_port_a: assert property (user_port_o != 3'h0)
		else $error("user port zero");
	loop_cmd_a: assert property ((loop_type_o != 2'h0) |-> loop_cmd_o <= 3'h1)
		else $error("loop command illegal for type");
	dds_cmd_a: assert property (loop_type_o != 2'h3 && loop_cmd_o <= 3'h4)
		else $error("loop type or command out of range");
	local_loopback_select_a: assert property (local_loopback_select_o != 2'h3)
		else $error("local loopback code illegal");
	out_hold_a: assert property (dout_valid_o && !dout_ready_i |=>
		dout_valid_o && $stable(dout_o))
		else $error("link data dropped while stalled");
	speed_c: cover property (slot_claim_o != '0 && speed_kbps_o != '0);
	user_c: cover property (dest_user_o);
	xfer_c: cover property (dout_valid_o && dout_ready_i);
endmodule
bind ds0_timeslot_port_mapper ds0_map_props #(.FIFO_W(FIFO_W)) u_props (
	.mclk_i(mclk_i), .rst_i(rst_i), .slot_claim_o(slot_claim_o),
	.speed_kbps_o(speed_kbps_o), .user_port_o(user_port_o), .cts_o(cts_o),
	.dce_o(dce_o), .dest_user_o(dest_user_o), .local_loopback_select_o(local_loopback_select_o),
	.loop_type_o(loop_type_o), .loop_cmd_o(loop_cmd_o), .dout_o(dout_o),
	.dout_valid_o(dout_valid_o), .dout_ready_i(dout_ready_i));
`default_nettype wire

/* sim/ds0_link_sink.sv */
// Link card model taking port data with periodic stalls
`timescale 1ns/1ps
`default_nettype none
module ds0_link_sink #(
	parameter logic [7:0] BASE = 8'ha0
) (
	input  wire logic       mclk_i,  // Clock
	input  wire logic       rst_i,   // Sync reset
	input  wire logic [7:0] data_i,  // Word from port
	input  wire logic       valid_i, // Word valid
	output var logic        ready_o, // Takes word
	output var logic  [7:0] cnt_o,   // Words taken
	output var logic        bad_o    // Out of order word seen
);
	logic [1:0] ph_q;
	always_ff @(posedge mclk_i) begin
		ph_q    <= rst_i ? 2'h0 : ph_q + 2'h1;
		// Stall one cycle in four
		ready_o <= !rst_i && ph_q != 2'h2;
		if (rst_i) begin
			cnt_o <= 8'h00;
			bad_o <= 1'b0;
		end else if (valid_i && ready_o) begin
			cnt_o <= cnt_o + 8'h01;
			if (data_i != BASE + cnt_o)
				bad_o <= 1'b1;
		end
	end
endmodule
`default_nettype wire

/* sim/ds0_timeslot_port_mapper_tb.sv */
// Self-checking bench for the time-slot port mapper
`timescale 1ns/1ps
`default_nettype none
module ds0_timeslot_port_mapper_tb;
	import ds0_map_pkg::*;
	logic        mclk_i, rst_i, wr_i, rd_i, din_valid_i, din_ready_o;
	logic [7:0]  addr_i, din_i, dout_o, snk_cnt;
	logic [31:0] wdata_i, rdata_o;
	logic [30:0] slot_claim_o;
	logic [10:0] speed_kbps_o;
	logic [2:0]  wan_port_o, user_slot_o, user_port_o, loop_cmd_o;
	logic [1:0]  local_loopback_select_o, loop_type_o;
	logic        dest_user_o, cts_o, dce_o, dout_valid_o, dout_ready_i, snk_bad;
	int          error_cnt, n_tests, cyc, n;
	ds0_timeslot_port_mapper DUT (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.slot_claim_o(slot_claim_o), .dest_user_o(dest_user_o), .wan_port_o(wan_port_o),
		.user_slot_o(user_slot_o), .user_port_o(user_port_o), .speed_kbps_o(speed_kbps_o),
		.cts_o(cts_o), .dce_o(dce_o), .local_loopback_select_o(local_loopback_select_o), .loop_type_o(loop_type_o),
		.loop_cmd_o(loop_cmd_o), .din_i(din_i), .din_valid_i(din_valid_i),
		.din_ready_o(din_ready_o), .dout_o(dout_o), .dout_valid_o(dout_valid_o),
		.dout_ready_i(dout_ready_i));
	ds0_link_sink u_sink (.mclk_i(mclk_i), .rst_i(rst_i), .data_i(dout_o),
		.valid_i(dout_valid_o), .ready_o(dout_ready_i), .cnt_o(snk_cnt), .bad_o(snk_bad));
	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end
	task automatic stop_test;
		$display("errors %0d checks %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge mclk_i);
		wr_i    <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge mclk_i);
		rd_i   <= 1'b0;
		#1 chk(rdata_o, exp);
	endtask
	task automatic settle;
		repeat (2) @(posedge mclk_i);
		#1;
	endtask
	function automatic logic [31:0] cw(input logic a, input logic [1:0] d,
		input logic [2:0] w, u, p, input logic r, input logic [1:0] l, t,
		input logic [2:0] c);
		return {12'h0, c, t, l, r, p, u, w, d, a};
	endfunction
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc > 3000) begin
			error_cnt++;
			stop_test;
		end
	end
	initial begin
		{wr_i, rd_i, din_valid_i, addr_i, din_i, wdata_i} = '0;
		{error_cnt, n_tests, cyc} = '0;
		rst_i = 1'b1;
		repeat (2) @(posedge mclk_i);
		rst_i <= 1'b0;
		rd(REG_STATUS, 32'h13);
		chk({cts_o, dce_o, dest_user_o, local_loopback_select_o, loop_type_o, loop_cmd_o}, 32'h300);
		chk({wan_port_o, user_port_o}, 32'h1);
		wr(REG_SLOTS, 32'hffffffff);
		settle;
		chk(32'(slot_claim_o), 32'h0);
		rd(REG_SLOTS, 32'h00ffffff);
		rd(REG_STATUS, 32'h00180013);
		wr(REG_CTRL, cw(1, 0, 7, 0, 0, 1, 0, 0, 0));
		settle;
		chk(32'(slot_claim_o), 32'h00ffffff);
		chk({speed_kbps_o, wan_port_o}, {11'd1536, 3'h7});
		wr(REG_LINK, 32'h3);
		wr(REG_SLOTS, 32'hffffffff);
		settle;
		rd(REG_SLOTS, 32'h7fff7fff);
		chk(speed_kbps_o, 11'd1920);
		wr(REG_LINK, 32'h1);
		wr(REG_SLOTS, 32'hffffffff);
		settle;
		chk(32'(slot_claim_o), 32'h7fffffff);
		chk(speed_kbps_o, 11'd1984);
		wr(REG_SLOTS, 32'h00000505);
		wr(REG_CTRL, cw(1, 0, 0, 0, 0, 0, 0, 0, 0));
		settle;
		chk(speed_kbps_o, 11'd224);
		wr(REG_CTRL, cw(1, 2, 0, 3, 4, 0, 0, 0, 0));
		#1 chk({dest_user_o, user_slot_o, user_port_o}, {1'b1, 3'h3, 3'h1});
		wr(REG_UPORTS, 32'h00000800);
		wr(REG_CTRL, cw(1, 2, 0, 3, 4, 0, 0, 0, 0));
		#1 chk(user_port_o, 3'h4);
		wr(REG_CTRL, cw(1, 2, 0, 3, 5, 0, 0, 0, 0));
		#1 chk(user_port_o, 3'h1);
		wr(REG_CTRL, cw(1, 1, 3, 3, 5, 0, 0, 0, 0));
		#1 chk({dest_user_o, wan_port_o}, {1'b1, 3'h3});
		for (int i = 0; i < 5; i++) begin
			wr(REG_CTRL, cw(1, 0, 0, 0, 0, 0, 2'(i % 3), 0, 3'(i)));
			#1 chk({local_loopback_select_o, loop_cmd_o}, {2'(i % 3), 3'(i)});
		end
		for (int t = 1; t < 3; t++) begin
			wr(REG_CTRL, cw(1, 0, 0, 0, 0, 0, 0, 2'(t), 1));
			#1 chk({loop_type_o, loop_cmd_o}, {2'(t), 3'h1});
			wr(REG_CTRL, cw(1, 0, 0, 0, 0, 0, 0, 2'(t), 2));
			#1 chk(loop_cmd_o, 3'h0);
		end
		wr(REG_CTRL, cw(1, 0, 0, 0, 0, 0, 2, 0, 3));
		wr(REG_CTRL, cw(1, 0, 0, 0, 0, 0, 3, 3, 6));
		#1 chk({local_loopback_select_o, loop_type_o, loop_cmd_o}, {2'h2, 2'h0, 3'h3});
		wr(8'h20, 32'hffffffff);
		rd(8'h20, 32'h0);
		wr(REG_CTRL, cw(0, 0, 0, 0, 0, 0, 0, 0, 0));
		@(posedge mclk_i);
		din_valid_i <= 1'b1;
		din_i <= 8'ha0;
		for (n = 0; n < 20; n++) begin
			#1 if (din_ready_o !== 1'b1) break;
			@(posedge mclk_i);
			din_i <= 8'ha1 + 8'(n);
		end
		@(posedge mclk_i);
		din_valid_i <= 1'b0;
		chk(n, FIFO_DEPTH);
		chk({dout_valid_o, snk_cnt}, 9'h0);
		chk(32'(slot_claim_o), 32'h0);
		wr(REG_CTRL, cw(1, 0, 0, 0, 0, 0, 0, 0, 0));
		for (int k = 0; k < 100 && snk_cnt != 8'(n); k++)
			@(posedge mclk_i);
		#1 chk({snk_bad, snk_cnt}, {1'b0, 8'(n)});
		stop_test;
	end
endmodule
`default_nettype wire
